// ===== bsr_pkg.sv
// Constants and types shared by the brain-float rounding datapath.
// Assumes a 64-bit floating-point register file and a 32-bit register bus.
package bsr_pkg;

    // ========================================================================
    // Rounding mode codes
    localparam logic [2:0] ROUND_NEAREST_EVEN          = 3'h0;
    localparam logic [2:0] ROUND_TOWARD_ZERO           = 3'h1;
    localparam logic [2:0] ROUND_TOWARD_NEGATIVE       = 3'h2;
    localparam logic [2:0] ROUND_TOWARD_POSITIVE       = 3'h3;
    localparam logic [2:0] ROUND_NEAREST_MAX_MAGNITUDE = 3'h4;
    localparam logic [2:0] DYNAMIC_ROUNDING_SELECT     = 3'h7;

    // ========================================================================
    // Encodings
    localparam logic [15:0] NARROW_NAN     = 16'h7FC0;
    localparam logic [31:0] FP32_CANON_NAN = 32'h7FC00000;
    localparam logic [7:0]  EXP_ALL_ONES   = 8'hFF;
    localparam logic [7:0]  EXP_ZERO       = 8'h00;

    // ========================================================================
    // Register map, byte addresses, and reset values
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK   = 4'h8;
    localparam logic [2:0] FRM_RESET  = 3'h0;

    // ========================================================================
    // Types
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bsr_bus_type;

    typedef struct packed {
        logic nv;
        logic dz;
        logic of;
        logic uf;
        logic nx;
    } bsr_flags_type;

    typedef struct packed {
        logic          ill;
        bsr_flags_type ff;
    } bsr_status_type;

    typedef struct packed {
        logic        valid;
        logic        narrow;
        logic        vector;
        logic        src_scalar;
        logic        undef;
        logic [2:0]  instruction_rounding_field;
        logic [63:0] operand;
    } bsr_req_type;

    typedef struct packed {
        logic          valid;
        logic          illegal;
        logic          narrow;
        logic          vector;
        bsr_flags_type flags;
        logic [63:0]   result;
    } bsr_resp_type;

    typedef struct packed {
        bsr_bus_type    bus;
        logic [31:0]    rdata;
        logic [2:0]     frm;
        bsr_status_type status;
        bsr_status_type mask;
        bsr_resp_type   resp;
    } bsr_state_type;

    localparam bsr_state_type STATE_RESET = '{
        bus:    BUS_IDLE,
        rdata:  32'h00000000,
        frm:    FRM_RESET,
        status: 6'h00,
        mask:   6'h00,
        resp:   '0
    };

endpackage

// ===== bsr_rounder.sv
// Rounds a finite single-precision magnitude to brain-float precision.
// Assumes the caller has removed NaN and infinite inputs.
`timescale 1ns/10ps
module bsr_rounder (
    input  wire logic [2:0]  mode_i,      // resolved rounding mode
    input  wire logic        sign_i,      // sign of the value
    input  wire logic [30:0] mag_i,       // exponent and fraction
    output logic      [14:0] mag_o,       // rounded exponent and fraction
    output logic             overflow_o,  // rounded past the largest finite
    output logic             underflow_o, // tiny after rounding and inexact
    output logic             inexact_o    // discarded bits were nonzero
);

    // ========================================================================
    // Rounding decision
    function automatic logic round_up(input logic [2:0] mode,
                                      input logic       sign,
                                      input logic       lsb,
                                      input logic       guard,
                                      input logic       sticky);
        logic up;
        up = 1'b0;
        case (mode)
            bsr_pkg::ROUND_NEAREST_EVEN:          up = guard & (sticky | lsb);
            bsr_pkg::ROUND_TOWARD_ZERO:           up = 1'b0;
            bsr_pkg::ROUND_TOWARD_NEGATIVE:       up = sign & (guard | sticky);
            bsr_pkg::ROUND_TOWARD_POSITIVE:       up = ~sign & (guard | sticky);
            bsr_pkg::ROUND_NEAREST_MAX_MAGNITUDE: up = guard;
            default:                              up = 1'b0;
        endcase
        return up;
    endfunction

    // ========================================================================
    // Final rounding
    // Both formats share exponent width and bias, so the final rounding is a
    // plain increment of the upper half; a carry moves subnormals into the
    // normal range and the largest finite values into infinity.
    logic        final_up;
    logic [15:0] sum;
    logic        tiny_up;
    logic        tiny;

    assign final_up = round_up(mode_i, sign_i, mag_i[16], mag_i[15],
                               |mag_i[14:0]);
    assign sum      = {1'b0, mag_i[30:16]} + {15'h0000, final_up};
    assign mag_o    = sum[14:0];
    assign inexact_o  = mag_i[15] | (|mag_i[14:0]);
    // Directed modes that round away from infinity stop at the largest
    // finite value, because they never increment.
    assign overflow_o = (sum[14:7] == bsr_pkg::EXP_ALL_ONES);

    // ========================================================================
    // Tininess with an unbounded exponent
    // Only a single-precision subnormal can be tiny. Normalised, it keeps
    // one more fraction bit than the denormalised final rounding, and it
    // escapes tininess only when it rounds up to the smallest normal.
    assign tiny_up = round_up(mode_i, sign_i, mag_i[15], mag_i[14],
                              |mag_i[13:0]);
    assign tiny    = (mag_i[30:23] == bsr_pkg::EXP_ZERO) &&
                     !((mag_i[22:15] == bsr_pkg::EXP_ALL_ONES) && tiny_up);
    assign underflow_o = tiny & inexact_o;

endmodule

// ===== bsr_core.sv
// Brain-float conversion datapath with special-value handling, rounding,
// flag accumulation and an Avalon-MM register slave.
// Assumes one clock for the core pipeline and the register bus.
`timescale 1ns/10ps
module bsr_core (
    input  wire logic                  ref_clk_i,         // core clock
    input  wire logic                  rst_i,             // async reset
    input  wire logic                  ce_i,              // clock enable
    input  wire bsr_pkg::bsr_req_type  req_i,             // operation request
    output logic                       req_ready_o,       // request taken
    output bsr_pkg::bsr_resp_type      resp_o,            // result and flags
    input  wire logic [3:0]            avs_address_i,     // byte address
    input  wire logic                  avs_read_i,        // read strobe
    input  wire logic                  avs_write_i,       // write strobe
    input  wire logic [31:0]           avs_writedata_i,   // write data
    input  wire logic [3:0]            avs_byteenable_i,  // byte lanes
    output logic [31:0]                avs_readdata_o,    // read data
    output logic                       avs_waitrequest_o, // slave stall
    output logic                       irq_o              // interrupt level
);

    // ========================================================================
    // Helpers
    function automatic logic mode_reserved(input logic [2:0] m);
        return m > bsr_pkg::ROUND_NEAREST_MAX_MAGNITUDE;
    endfunction

    function automatic logic is_nan16(input logic [15:0] v);
        return (v[14:7] == bsr_pkg::EXP_ALL_ONES) && (v[6:0] != 7'h00);
    endfunction

    // ========================================================================
    // State
    bsr_pkg::bsr_state_type st_ff;
    bsr_pkg::bsr_state_type nxt_st;

    // ========================================================================
    // Operand selection and classification
    logic [2:0]  eff_mode;
    logic        mode_bad;
    logic        box_ok;
    logic [31:0] src32;
    logic [15:0] src16;
    logic        n_nan;
    logic        n_trap;
    logic        n_inf;
    logic        w_nan;
    logic        w_trap;
    logic [14:0] rnd_mag;
    logic        rnd_of;
    logic        rnd_uf;
    logic        rnd_nx;
    logic        take;

    assign eff_mode = (req_i.vector || req_i.instruction_rounding_field ==
                       bsr_pkg::DYNAMIC_ROUNDING_SELECT) ?
                      st_ff.frm
                      : req_i.instruction_rounding_field;
    assign mode_bad = req_i.narrow && mode_reserved(eff_mode);

    assign box_ok = !req_i.src_scalar ||
                    (req_i.narrow ? (&req_i.operand[63:32])
                                  : (&req_i.operand[63:16]));
    assign src32  = box_ok ? req_i.operand[31:0]
                           : bsr_pkg::FP32_CANON_NAN;
    assign src16  = box_ok ? req_i.operand[15:0]
                           : bsr_pkg::NARROW_NAN;

    // Sign, eight exponent bits and the fraction sit exactly as in the upper
    // half of the single-precision word.
    assign n_nan  = (src32[30:23] == bsr_pkg::EXP_ALL_ONES) &&
                    (src32[22:0] != 23'h000000);
    assign n_trap = n_nan && !src32[22];
    assign n_inf  = (src32[30:23] == bsr_pkg::EXP_ALL_ONES) &&
                    (src32[22:0] == 23'h000000);
    assign w_nan  = is_nan16(src16);
    assign w_trap = w_nan && !src16[6];

    assign take = req_i.valid && req_ready_o;

    bsr_rounder u_rounder (
        .mode_i      (eff_mode),
        .sign_i      (src32[31]),
        .mag_i       (src32[30:0]),
        .mag_o       (rnd_mag),
        .overflow_o  (rnd_of),
        .underflow_o (rnd_uf),
        .inexact_o   (rnd_nx)
    );

    // ========================================================================
    // Next state
    logic [5:0] clr;
    logic [5:0] set;

    always_comb begin
        nxt_st = st_ff;
        clr = 6'h00;
        set = 6'h00;

        // Datapath response.
        nxt_st.resp.valid = 1'b0;
        if (req_i.valid) begin
            nxt_st.resp.valid   = 1'b1;
            nxt_st.resp.narrow  = req_i.narrow;
            nxt_st.resp.vector  = req_i.vector;
            nxt_st.resp.illegal = mode_bad;
            nxt_st.resp.flags   = '0;
            nxt_st.resp.result  = 64'h0000000000000000;
            if (mode_bad) begin
                nxt_st.resp.result = 64'h0000000000000000;
            end else if (req_i.narrow) begin
                if (req_i.undef) begin
                    nxt_st.resp.result[15:0] = bsr_pkg::NARROW_NAN;
                    nxt_st.resp.flags.nv     = 1'b1;
                end else if (n_nan) begin
                    // Quieting and canonicalising keeps signalling NaNs out.
                    nxt_st.resp.result[15:0] =
                        bsr_pkg::NARROW_NAN;
                    nxt_st.resp.flags.nv     = n_trap;
                end else if (n_inf) begin
                    nxt_st.resp.result[15:0] = src32[31:16];
                end else begin
                    nxt_st.resp.result[15:0] = {src32[31], rnd_mag};
                    nxt_st.resp.flags.of     = rnd_of;
                    nxt_st.resp.flags.uf     = rnd_uf;
                    nxt_st.resp.flags.nx     = rnd_nx;
                end
                if (!req_i.vector) begin
                    nxt_st.resp.result[63:16] = '1;
                end
            end else begin
                if (req_i.undef) begin
                    nxt_st.resp.result[31:0] = bsr_pkg::FP32_CANON_NAN;
                    nxt_st.resp.flags.nv     = 1'b1;
                end else if (w_nan) begin
                    nxt_st.resp.result[31:0] = bsr_pkg::FP32_CANON_NAN;
                    nxt_st.resp.flags.nv     = w_trap;
                end else begin
                    // Widening is exact, subnormals included.
                    nxt_st.resp.result[31:0] = {src16, 16'h0000};
                end
                if (!req_i.vector) begin
                    nxt_st.resp.result[63:32] = '1;
                end
            end
            set = {mode_bad, nxt_st.resp.flags};
        end

        // Register slave: sample read data on the first cycle, commit the
        // write on the cycle that waitrequest drops.
        case (st_ff.bus)
            bsr_pkg::BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    nxt_st.bus   = bsr_pkg::BUS_ACK;
                    nxt_st.rdata = 32'h00000000;
                    if (avs_address_i == bsr_pkg::REG_CTRL) begin
                        nxt_st.rdata[2:0] = st_ff.frm;
                    end else if (avs_address_i == bsr_pkg::REG_STATUS) begin
                        nxt_st.rdata[5:0] = st_ff.status;
                    end else if (avs_address_i == bsr_pkg::REG_MASK) begin
                        nxt_st.rdata[5:0] = st_ff.mask;
                    end
                end
            end
            bsr_pkg::BUS_ACK: begin
                nxt_st.bus = bsr_pkg::BUS_IDLE;
                if (avs_write_i && avs_byteenable_i[0]) begin
                    if (avs_address_i == bsr_pkg::REG_CTRL) begin
                        // Reserved codes are stored and refused at use.
                        nxt_st.frm = avs_writedata_i[2:0];
                    end else if (avs_address_i == bsr_pkg::REG_STATUS) begin
                        clr = avs_writedata_i[5:0];
                    end else if (avs_address_i == bsr_pkg::REG_MASK) begin
                        nxt_st.mask = avs_writedata_i[5:0];
                    end
                end
            end
            default: begin
                nxt_st.bus = bsr_pkg::BUS_IDLE;
            end
        endcase

        // A flag raised in the cycle it is cleared stays set.
        nxt_st.status = (st_ff.status & ~clr) | set;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= bsr_pkg::STATE_RESET;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // ========================================================================
    // Outputs
    assign req_ready_o       = ce_i && !rst_i;
    assign resp_o            = st_ff.resp;
    assign avs_readdata_o    = st_ff.rdata;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) &&
                               (st_ff.bus == bsr_pkg::BUS_IDLE);
    assign irq_o             = |(st_ff.status & st_ff.mask);

    // ========================================================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_trap_take;
        take && req_i.narrow && n_trap && !mode_bad && !req_i.undef;
    endsequence

    sequence s_invalid_resp;
        resp_o.valid && resp_o.flags.nv &&
        (resp_o.result[15:0] == bsr_pkg::NARROW_NAN);
    endsequence

    sequence s_dyn_bad_take;
        take && req_i.narrow && !req_i.vector &&
        (req_i.instruction_rounding_field ==
         bsr_pkg::DYNAMIC_ROUNDING_SELECT) &&
        mode_reserved(st_ff.frm);
    endsequence

    chk_trap_invalid: assert property (s_trap_take |=> s_invalid_resp)
        else $error("signalling NaN operand did not raise invalid");

    chk_no_signalling_not_a_number_out: assert property (
        resp_o.valid && resp_o.narrow && is_nan16(resp_o.result[15:0])
        |-> resp_o.result[6])
        else $error("signalling NaN produced as a result");

    chk_canon_nan: assert property (
        resp_o.valid && resp_o.narrow && is_nan16(resp_o.result[15:0])
        |-> resp_o.result[15:0] == bsr_pkg::NARROW_NAN)
        else $error("NaN result is not canonical");

    chk_box_upper: assert property (
        resp_o.valid && !resp_o.illegal && resp_o.narrow && !resp_o.vector
        |-> &resp_o.result[63:16])
        else $error("scalar result not boxed with ones");

    chk_bad_box: assert property (
        take && req_i.narrow && req_i.src_scalar && !mode_bad &&
        !req_i.undef && !(&req_i.operand[63:32])
        |=> resp_o.result[15:0] == bsr_pkg::NARROW_NAN &&
            !resp_o.flags.nv)
        else $error("badly boxed operand not read as canonical NaN");

    chk_dyn_illegal: assert property (
        s_dyn_bad_take |=> resp_o.valid && resp_o.illegal &&
                           resp_o.flags == '0 ##1 st_ff.status.ill)
        else $error("reserved dynamic mode not refused");

    chk_undef_nan: assert property (
        take && req_i.undef && !mode_bad && req_i.narrow
        |=> s_invalid_resp)
        else $error("undefined result did not give a quiet NaN");

    chk_uf_nx: assert property (
        resp_o.valid && resp_o.flags.uf |-> resp_o.flags.nx)
        else $error("underflow raised without inexact");

    chk_flag_sticky: assert property (
        resp_o.valid && !resp_o.illegal && resp_o.flags.nx ##1 ce_i
        |-> st_ff.status.ff.nx)
        else $error("inexact flag not accumulated");

    chk_subnormal_kept: assert property (
        take && req_i.narrow && !mode_bad && !req_i.undef &&
        (src32[30:23] == bsr_pkg::EXP_ZERO) && (src32[22:16] != 7'h00)
        |=> resp_o.result[14:0] != 15'h0000)
        else $error("subnormal result flushed to zero");

    chk_widen_exact: assert property (
        take && !req_i.narrow && !req_i.undef && !w_nan
        |=> resp_o.result[31:0] == {$past(src16), 16'h0000})
        else $error("widened value not exact");

    chk_inf_kept: assert property (
        take && req_i.narrow && n_inf && !mode_bad && !req_i.undef
        |=> resp_o.result[15:0] == $past(src32[31:16]) &&
            resp_o.flags == '0)
        else $error("infinite operand not passed through");

    chk_uf_range: assert property (
        resp_o.valid && resp_o.narrow && resp_o.flags.uf
        |-> resp_o.result[14:7] <= 8'h01)
        else $error("underflow on a result above the smallest normal");

    chk_reserved_mode: assert property (
        take && req_i.narrow && mode_reserved(eff_mode)
        |=> resp_o.illegal && resp_o.result == 64'h0000000000000000)
        else $error("reserved rounding mode not refused");

endmodule

// ===== bsr_pipe_model.sv
// Core pipeline model that presents requests to the rounding datapath.
// Assumes the bench calls issue and idle right after a rising edge.
`timescale 1ns/10ps
module bsr_pipe_model (
    input  wire logic            ref_clk_i, // core clock
    input  wire logic            ready_i,   // datapath takes request
    output bsr_pkg::bsr_req_type req_o      // request to datapath
);
    initial req_o = '0;

    task automatic issue(input bsr_pkg::bsr_req_type r, output logic ok);
        ok = 1'b0;
        req_o <= r;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge ref_clk_i);
            ok = ready_i;
        end
    endtask

    // Going idle inverts the operand once, so stale data is never reused.
    task automatic idle();
        req_o.valid   <= 1'b0;
        req_o.operand <= ~req_o.operand;
    endtask
endmodule

// ===== bsr_core_tb_top.sv
// Self-checking bench for the brain-float datapath and register slave.
// Assumes bsr_pkg, bsr_core and bsr_pipe_model are compiled first.
`timescale 1ns/10ps
module bsr_core_tb_top;
    // ==========
    // Signals and model state
    logic                  ref_clk_i = 1'b0;
    logic                  rst_i     = 1'b1;
    logic                  ce_i      = 1'b1;
    logic                  rdy;
    logic [3:0]            adr       = 4'h0;
    logic                  rd        = 1'b0;
    logic                  wr        = 1'b0;
    logic [31:0]           wdat      = 32'h00000000;
    logic [3:0]            ben       = 4'hF;
    logic [31:0]           rdat;
    logic                  wrq;
    logic                  irq;
    logic                  tkn       = 1'b0;
    logic [2:0]            frm_m     = 3'h0;
    logic [5:0]            st_m      = 6'h00;
    logic [31:0]           lfsr      = 32'hCAAC63B2;
    logic [31:0]           q;
    logic [31:0]           ops [0:6] = '{32'h7F7FFFFF, 32'hFF7FFFFF,
        32'h3F808000, 32'hBF818000, 32'h007F8000, 32'h007FFFFF, 32'h00012345};
    logic [31:0]           sp [0:3]  = '{32'h7F810001, 32'hFFC12345,
        32'hFF800000, 32'h00010000};
    bsr_pkg::bsr_req_type  req;
    bsr_pkg::bsr_resp_type resp;
    bsr_pkg::bsr_resp_type e_m;
    bsr_pkg::bsr_resp_type exp_q[$];
    int                    n_fail    = 0;
    int                    n_tests   = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    bsr_core u_bsr_core (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req),
        .req_ready_o(rdy), .resp_o(resp), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(ben), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wrq), .irq_o(irq)
    );
    bsr_pipe_model u_bsr_pipe_model (
        .ref_clk_i(ref_clk_i), .ready_i(rdy), .req_o(req)
    );

    // ==========
    // Reference model
    function automatic logic rnd_up(input logic [2:0] md, input logic s,
            input logic lsb, input logic g, input logic st);
        case (md)
            3'h0: return g & (st | lsb);
            3'h1: return 1'b0;
            3'h2: return s & (g | st);
            3'h3: return !s & (g | st);
            default: return g;
        endcase
    endfunction

    function automatic bsr_pkg::bsr_resp_type model(
            input bsr_pkg::bsr_req_type r);
        logic [2:0]  md;
        logic [31:0] x;
        logic [15:0] y;
        logic [15:0] rn;
        logic        nx;
        model = '0;
        model.valid = 1'b1;
        model.narrow = r.narrow;
        model.vector = r.vector;
        md = (r.vector || r.instruction_rounding_field == 3'h7) ? frm_m :
            r.instruction_rounding_field;
        x = r.undef ? 32'h7FC00000 : r.operand[31:0];
        y = r.undef ? 16'h7FC0 : r.operand[15:0];
        if (r.src_scalar && !(&r.operand[63:32]))
            x = 32'h7FC00000;
        if (r.src_scalar && !(&r.operand[63:16]))
            y = 16'h7FC0;
        if (r.narrow && md > 3'h4) begin
            model.illegal = 1'b1;
        end else if (r.narrow) begin
            nx = |x[15:0];
            rn = {1'b0, x[30:16]} + 16'(rnd_up(md, x[31], x[16], x[15],
                |x[14:0]));
            if (&x[30:23]) begin
                y = (|x[22:0]) ? 16'h7FC0 : x[31:16];
                model.flags.nv = (|x[22:0]) & !x[22];
            end else begin
                y = {x[31], rn[14:0]};
                model.flags.of = &rn[14:7];
                model.flags.nx = nx;
                model.flags.uf = nx && x[30:23] == 8'h00 && !(&x[22:15] &&
                    rnd_up(md, x[31], x[15], x[14], |x[13:0]));
            end
            model.result = {r.vector ? 48'h0 : 48'hFFFFFFFFFFFF, y};
        end else begin
            x = (&y[14:7] && |y[6:0]) ? 32'h7FC00000 : {y, 16'h0000};
            model.flags.nv = &y[14:7] && |y[6:0] && !y[6];
            model.result = {r.vector ? 32'h0 : 32'hFFFFFFFF, x};
        end
        model.flags.nv = model.flags.nv | (r.undef & !model.illegal);
    endfunction

    function automatic bsr_pkg::bsr_req_type mk(input logic n, input logic v,
            input logic [2:0] m, input logic [31:0] x);
        mk = '0;
        mk.valid = 1'b1;
        mk.narrow = n;
        mk.vector = v;
        mk.src_scalar = !v;
        mk.instruction_rounding_field = m;
        mk.operand = v ? {32'h0, x} : n ? {32'hFFFFFFFF, x} :
            {48'hFFFFFFFFFFFF, x[15:0]};
    endfunction

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // ==========
    // Checking and bus tasks
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [72:0] g, input logic [72:0] x,
            input string s);
        n_tests++;
        if (g !== x) begin
            n_fail++;
            $display("Error %0t: %s got %h exp %h", $time, s, g, x);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d);
        int k;
        k = 0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge ref_clk_i);
        while (wrq !== 1'b0 && k < 20) begin
            k++;
            @(posedge ref_clk_i);
        end
        chk(73'(k < 20), 73'(1), "bus wait");
        if (k == 20)
            print_verdict();
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(73'(q), 73'(x), "register");
    endtask

    task automatic op(input bsr_pkg::bsr_req_type r);
        logic ok;
        exp_q.push_back(model(r));
        u_bsr_pipe_model.issue(r, ok);
        chk(73'(ok), 73'(1), "request taken");
        if (!ok)
            print_verdict();
    endtask

    task automatic drain();
        u_bsr_pipe_model.idle();
        repeat (3) @(posedge ref_clk_i);
    endtask

    // Responses are looked at mid-cycle, where registered outputs stand.
    always @(negedge ref_clk_i) begin
        if (!rst_i) begin
            chk(73'(resp.valid), 73'(tkn), "valid timing");
            if (resp.valid === 1'b1 && exp_q.size() > 0) begin
                e_m = exp_q.pop_front();
                chk(resp, e_m, "response");
                st_m = st_m | {e_m.illegal, e_m.flags};
            end
            tkn = req.valid === 1'b1 && rdy === 1'b1;
        end
    end

    // ==========
    // Main sequence
    initial begin
        bsr_pkg::bsr_req_type r;
        logic [2:0]           m;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rchk(bsr_pkg::REG_CTRL, 32'h0);
        rchk(bsr_pkg::REG_STATUS, 32'h0);
        for (int i = 0; i < 5; i++)
            foreach (ops[j])
                op(mk(1'b1, 1'b0, 3'(i), ops[j]));
        foreach (sp[j])
            op(mk(1'b1, 1'b0, 3'h0, sp[j]));
        foreach (sp[j])
            op(mk(1'b0, 1'b0, 3'h5, sp[j] >> 16));
        r = mk(1'b1, 1'b0, 3'h0, 32'h3F800000);
        r.operand[40] = 1'b0;
        op(r);
        r = mk(1'b0, 1'b0, 3'h0, 32'h00003F80);
        r.operand[20] = 1'b0;
        op(r);
        r = mk(1'b1, 1'b0, 3'h0, 32'h3F800000);
        r.undef = 1'b1;
        op(r);
        drain();
        bus(1'b1, bsr_pkg::REG_CTRL, 32'hFFFFFFF3);
        frm_m = 3'h3;
        ben <= 4'hE;
        bus(1'b1, bsr_pkg::REG_CTRL, 32'h0);
        ben <= 4'hF;
        rchk(bsr_pkg::REG_CTRL, 32'h3);
        op(mk(1'b1, 1'b0, 3'h7, 32'h3F808001));
        op(mk(1'b1, 1'b1, 3'h0, 32'hBF808001));
        op(mk(1'b0, 1'b1, 3'h0, 32'h00000080));
        drain();
        bus(1'b1, bsr_pkg::REG_CTRL, 32'h5);
        frm_m = 3'h5;
        for (int i = 5; i < 8; i++)
            op(mk(1'b1, 1'b0, 3'(i), 32'h3F800000));
        op(mk(1'b1, 1'b1, 3'h0, 32'h3F800000));
        drain();
        bus(1'b1, bsr_pkg::REG_CTRL, 32'h2);
        frm_m = 3'h2;
        for (int i = 0; i < 300; i++) begin
            lfsr = lfsr_next(lfsr);
            m = (lfsr[2:0] > 3'h4) ? 3'h7 : lfsr[2:0];
            r = mk(lfsr[3], lfsr[4], m, {lfsr[31:24] ^ lfsr[7:0], 
                lfsr[23:0]} & (lfsr[5] ? 32'h807FFFFF : 32'hFFFFFFFF));
            op(r);
        end
        drain();
        rchk(bsr_pkg::REG_STATUS, {26'h0, st_m});
        bus(1'b1, bsr_pkg::REG_MASK, 32'h10);
        chk(73'(irq), 73'(st_m[4]), "irq masked");
        bus(1'b1, bsr_pkg::REG_STATUS, 32'h3F);
        st_m = 6'h00;
        rchk(bsr_pkg::REG_STATUS, 32'h0);
        chk(73'(irq), 73'(0), "irq cleared");
        op(mk(1'b1, 1'b0, 3'h0, 32'h7F810001));
        drain();
        chk(73'(irq), 73'(1), "irq raised");
        bus(1'b1, bsr_pkg::REG_MASK, 32'h0);
        chk(73'(irq), 73'(0), "irq mask off");
        rchk(4'hC, 32'h0);
        // A request held while the clock enable is low waits for it.
        ce_i <= 1'b0;
        fork begin
            repeat (4) @(posedge ref_clk_i);
            ce_i <= 1'b1;
        end join_none
        op(mk(1'b0, 1'b0, 3'h0, 32'h00003F80));
        drain();
        chk(73'(exp_q.size()), 73'(0), "all answered");
        print_verdict();
    end
endmodule
